// File: design/fcr_flash_read.sv
// continuous main-array read front end, link side and top level
module fcr_flash_read
  import fcr_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic interface_select_i,
  input wire logic page_binary_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  input wire logic [7:0] pio_i,
  output logic [7:0] pio_o,
  output logic [7:0] pio_oe_o,
  output logic [PAGE_W-1:0] arr_page_o,
  output logic [COL_W-1:0] arr_col_o,
  input wire logic [7:0] arr_data_i,
  output logic read_active_o,
  output logic cmd_start_o,
  output logic serial_mode_o
);

  fcr_cdc_if cdc ();

  // system side owns configuration and status toward software
  fcr_sys_ctl u_sys (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .interface_select_i(interface_select_i),
    .page_binary_i(page_binary_i),
    .cdc(cdc.sys),
    .read_active_o(read_active_o),
    .cmd_start_o(cmd_start_o),
    .serial_mode_o(serial_mode_o)
  );

  // frame reset: chip select high clears the link logic at once
  logic lnk_rst;
  assign lnk_rst = sys_rst_i | cs_n_i;

  // configuration crossing into the link clock, not cleared per frame
  logic ser_meta_q, ser_q, bin_meta_q, bin_q;
  logic ser_meta_d, ser_d, bin_meta_d, bin_d;

  always_comb begin
    ser_meta_d = cdc.cfg_ser;
    ser_d = ser_meta_q;
    bin_meta_d = cdc.cfg_bin;
    bin_d = bin_meta_q;
  end

  always_ff @(posedge sck_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ser_meta_q <= 1'b1;
      ser_q <= 1'b1;
      bin_meta_q <= 1'b0;
      bin_q <= 1'b0;
    end else begin
      ser_meta_q <= ser_meta_d;
      ser_q <= ser_d;
      bin_meta_q <= bin_meta_d;
      bin_q <= bin_d;
    end
  end

  // command framing state, sampled on the rising clock edge
  fcr_state_e st_q, st_d;
  logic [2:0] bit_q, bit_d;
  logic [4:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] opc_q, opc_d;
  logic [15:0] addr_q, addr_d;
  logic [PAGE_W-1:0] page_q, page_d;
  logic [COL_W-1:0] col_q, col_d;
  logic tgl_q, tgl_d;
  logic [7:0] in_byte;
  logic byte_done, op_ok, step;
  logic [23:0] full_addr;
  logic [4:0] dummies;
  logic [COL_W-1:0] last_col;

  // input byte assembly: serial shifts msb first, parallel takes a byte
  always_comb begin
    in_byte = ser_q ? {sh_q[6:0], si_i} : pio_i; // [RL2] [RL3] [RL19]
    byte_done = ser_q ? (bit_q == BIT_LAST) : 1'b1; // [RL20]
    full_addr = {addr_q, in_byte};
    last_col = bin_q ? LAST_COL_BIN : LAST_COL_STD;
    op_ok = (in_byte == OPC_LEGACY) ||
            (ser_q && ((in_byte == OPC_HIGH) || (in_byte == OPC_LOW)));
    // dummy length depends on opcode and port
    if (opc_q == OPC_LEGACY) begin
      dummies = ser_q ? DUMMY_LEGACY_SER : DUMMY_LEGACY_PAR; // [RL7]
    end else if (opc_q == OPC_HIGH) begin
      dummies = DUMMY_HIGH; // [RL15]
    end else begin
      dummies = DUMMY_NONE; // [RL16]
    end
  end

  // next-state logic of the command sequencer and address counter
  always_comb begin
    st_d = st_q;
    bit_d = ser_q ? 3'(bit_q + 3'h1) : 3'h0; // [RL9]
    cnt_d = cnt_q;
    sh_d = {sh_q[6:0], si_i};
    opc_d = opc_q;
    addr_d = addr_q;
    page_d = page_q;
    col_d = col_q;
    tgl_d = tgl_q;
    step = 1'b0;
    unique case (st_q)
      FCR_OPC: begin
        if (byte_done) begin
          opc_d = in_byte; // [RL1]
          cnt_d = 5'h00;
          if (op_ok) begin
            st_d = FCR_ADDR;
            tgl_d = cs_n_i ? tgl_q : ~tgl_q; // idle clocks never count
          end else begin
            st_d = FCR_IGNORE;
          end
        end
      end
      FCR_ADDR: begin
        if (byte_done) begin
          addr_d = {addr_q[7:0], in_byte};
          cnt_d = 5'(cnt_q + 5'h01);
          if (cnt_q[1:0] == ADDR_LAST_BYTE) begin
            if (bin_q) begin
              page_d = full_addr[BIN_PAGE_LSB +: PAGE_W]; // [RL5]
              col_d = {1'b0, full_addr[BUF_BYTE_W_BIN-1:0]}; // [RL6]
            end else begin
              page_d = full_addr[STD_PAGE_LSB +: PAGE_W]; // [RL4]
              col_d = full_addr[BUF_BYTE_W_STD-1:0]; // [RL6]
            end
            if (dummies == DUMMY_NONE) begin
              st_d = FCR_DATA; // [RL16]
            end else begin
              st_d = FCR_DUMMY;
              cnt_d = 5'(dummies - 5'h01);
            end
          end
        end
      end
      FCR_DUMMY: begin
        if (byte_done) begin
          if (cnt_q == 5'h00) begin
            st_d = FCR_DATA; // [RL7] [RL15]
          end else begin
            cnt_d = 5'(cnt_q - 5'h01);
          end
        end
      end
      FCR_DATA: begin
        // advance by byte at the end of each byte, wrapping with no gap
        step = byte_done; // [RL9] [RL20]
        if (byte_done) begin
          if (col_q >= last_col) begin
            col_d = '0; // [RL10]
            page_d = PAGE_W'(page_q + 1'b1); // [RL11]
          end else begin
            col_d = COL_W'(col_q + 1'b1);
          end
        end
      end
      FCR_IGNORE: begin
        st_d = FCR_IGNORE;
      end
    endcase
  end

  always_ff @(posedge sck_i or posedge lnk_rst) begin
    if (lnk_rst) begin
      st_q <= FCR_OPC;
      bit_q <= 3'h0;
      cnt_q <= 5'h00;
      sh_q <= 8'h00;
      opc_q <= 8'h00;
      addr_q <= 16'h0000;
      page_q <= '0;
      col_q <= '0;
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      opc_q <= opc_d;
      addr_q <= addr_d;
      page_q <= page_d;
      col_q <= col_d;
    end
  end

  // command toggle survives chip select so the system side sees each one
  always_ff @(posedge sck_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tgl_q <= 1'b0;
    end else begin
      tgl_q <= tgl_d;
    end
  end

  // the array is read only; no buffer or program path exists here
  assign arr_page_o = page_q; // [RL14] [RL17]
  assign arr_col_o = col_q;
  assign cdc.lnk_cmd_tgl = tgl_q;
  assign cdc.lnk_active = (st_q == FCR_DATA);

  // output stage on the falling edge, so modes 0 and 3 both see data early
  logic so_q, so_d, so_oe_q, so_oe_d;
  logic [7:0] pio_q, pio_d, pio_oe_q, pio_oe_d;

  always_comb begin
    so_d = 1'b0;
    so_oe_d = 1'b0;
    pio_d = 8'h00;
    pio_oe_d = 8'h00;
    if (st_q == FCR_DATA) begin
      if (ser_q) begin
        so_d = arr_data_i[3'(BIT_LAST - bit_q)]; // [RL2] [RL8]
        so_oe_d = 1'b1; // [RL19]
      end else begin
        pio_d = arr_data_i; // [RL8] [RL20]
        pio_oe_d = 8'hff; // [RL19]
      end
    end
  end

  // chip select rise clears the enables without waiting for a clock
  always_ff @(negedge sck_i or posedge lnk_rst) begin
    if (lnk_rst) begin
      so_q <= 1'b0; // [RL13]
      so_oe_q <= 1'b0;
      pio_q <= 8'h00;
      pio_oe_q <= 8'h00;
    end else begin
      so_q <= so_d; // [RL18]
      so_oe_q <= so_oe_d;
      pio_q <= pio_d;
      pio_oe_q <= pio_oe_d;
    end
  end

  assign so_o = so_q;
  assign so_oe_o = so_oe_q;
  assign pio_o = pio_q;
  assign pio_oe_o = pio_oe_q;

  // checks of the link behaviour
  sequence s_last_dummy;
    (st_q == FCR_DUMMY) && (cnt_q == 5'h00) && byte_done;
  endsequence

  sequence s_page_end;
    (st_q == FCR_DATA) && step && (col_q >= last_col);
  endsequence

  property p_float_on_cs;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      cs_n_i |-> (!so_oe_o && (pio_oe_o == 8'h00));
  endproperty
  a_float_on_cs: assert property (p_float_on_cs) // [RL13]
    else $error("outputs driven while chip select is high");

  property p_opcode_accept;
    @(posedge sck_i) disable iff (lnk_rst)
      (st_q == FCR_OPC) && byte_done |=>
        (st_q == ($past(op_ok) ? FCR_ADDR : FCR_IGNORE));
  endproperty
  a_opcode_accept: assert property (p_opcode_accept) // [RL1]
    else $error("opcode not taken after eight bits");

  property p_low_no_dummy;
    @(posedge sck_i) disable iff (lnk_rst)
      (st_q == FCR_ADDR) && byte_done && (cnt_q[1:0] == ADDR_LAST_BYTE)
        && (opc_q == OPC_LOW) |=> (st_q == FCR_DATA);
  endproperty
  a_low_no_dummy: assert property (p_low_no_dummy) // [RL16]
    else $error("low frequency read did not start data");

  property p_dummy_load;
    @(posedge sck_i) disable iff (lnk_rst)
      $rose(st_q == FCR_DUMMY) |->
        (cnt_q == 5'((opc_q == OPC_HIGH) ? 5'h00 :
          (ser_q ? 5'h03 : 5'h12)));
  endproperty
  a_dummy_load: assert property (p_dummy_load) // [RL7] [RL15]
    else $error("wrong dummy count loaded");

  property p_dummy_end;
    @(posedge sck_i) disable iff (lnk_rst)
      s_last_dummy |=> (st_q == FCR_DATA);
  endproperty
  a_dummy_end: assert property (p_dummy_end) // [RL7]
    else $error("data phase did not follow the dummies");

  property p_page_cross;
    @(posedge sck_i) disable iff (lnk_rst)
      s_page_end |=> (col_q == '0) && (st_q == FCR_DATA)
        && (page_q == PAGE_W'($past(page_q) + 1'b1));
  endproperty
  a_page_cross: assert property (p_page_cross) // [RL10] [RL11]
    else $error("page crossover not seamless");

  property p_col_step;
    @(posedge sck_i) disable iff (lnk_rst)
      (st_q == FCR_DATA) && step && (col_q < last_col) |=>
        (col_q == COL_W'($past(col_q) + 1'b1)) && $stable(page_q);
  endproperty
  a_col_step: assert property (p_col_step) // [RL9]
    else $error("read address did not advance by one byte");

  property p_port_exclusive;
    @(posedge sck_i) disable iff (lnk_rst)
      ser_q ? (pio_oe_o == 8'h00) : !so_oe_o;
  endproperty
  a_port_exclusive: assert property (p_port_exclusive) // [RL19]
    else $error("unselected port is driven");

  property p_par_byte_rate;
    @(posedge sck_i) disable iff (lnk_rst)
      (st_q == FCR_DATA) && !ser_q && (col_q < last_col) ##1
        (st_q == FCR_DATA) |-> (col_q == COL_W'($past(col_q) + 1'b1));
  endproperty
  a_par_byte_rate: assert property (p_par_byte_rate) // [RL20]
    else $error("parallel read not one byte per clock");

endmodule

// File: design/fcr_pkg.sv
// constants, state codes and field layout for the continuous array read
//
// Overview of operation
// RL1 - chip select fall opens an instruction: 8-bit opcode then address bytes
// RL2 - opcode, address and data move most significant bit first
// RL3 - while chip select is low each clock loads serial or parallel input
// RL4 - 1056-byte pages: top 13 address bits pick page, low 11 the byte
// RL5 - 1024-byte pages: bits 22..10 pick page, bits 9..0 the byte
// RL6 - buffer byte index is 11 bits standard, 10 bits binary
// RL7 - opcode e8 needs 3 address bytes then 4 serial or 19 parallel dummies
// RL8 - after the header every clock drives read data onto the active port
// RL9 - internal read address counter advances every clock, no re-addressing; the code steps it once per byte, every 8 clocks in serial mode
// RL10 - end of a page continues at next page start with no wait cycles
// RL11 - end of the whole array wraps to the first page without delay
// RL12 - host keeps chip select low through header and the whole readout
// RL13 - chip select rise ends the read and floats the active outputs
// RL14 - continuous reads fetch from the array and leave both buffers intact
// RL15 - opcode 0b, serial only: 3 address bytes, one dummy, up to 66 MHz
// RL16 - opcode 03, serial: data right after address, up to 33 MHz
// RL17 - array is programmed only in whole pages; erase by page upward
// RL18 - both ports work in clock mode 0 and clock mode 3
// RL19 - interface select high: serial pins; low: parallel port
// RL20 - parallel mode moves one byte per clock and counts bytes
package fcr_pkg;

  // opcodes
  localparam logic [7:0] OPC_LEGACY = 8'he8;
  localparam logic [7:0] OPC_HIGH = 8'h0b;
  localparam logic [7:0] OPC_LOW = 8'h03;

  // dummy byte counts per opcode and port
  localparam logic [4:0] DUMMY_LEGACY_SER = 5'h04;
  localparam logic [4:0] DUMMY_LEGACY_PAR = 5'h13;
  localparam logic [4:0] DUMMY_HIGH = 5'h01;
  localparam logic [4:0] DUMMY_NONE = 5'h00;

  // address layout
  localparam int PAGE_W = 13;
  localparam int COL_W = 11;
  localparam int STD_PAGE_LSB = 11;
  localparam int BIN_PAGE_LSB = 10;
  localparam int BUF_BYTE_W_STD = 11;
  localparam int BUF_BYTE_W_BIN = 10;
  localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;
  localparam logic [COL_W-1:0] LAST_COL_STD = 11'h41f;
  localparam logic [COL_W-1:0] LAST_COL_BIN = 11'h3ff;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // documented clock limits of the two serial read opcodes
  localparam int HIGH_READ_CLOCK_LIMIT_MHZ = 66;
  localparam int LOW_READ_CLOCK_LIMIT_MHZ = 33;

  typedef enum logic [4:0] {
    FCR_OPC = 5'b00001,
    FCR_ADDR = 5'b00010,
    FCR_DUMMY = 5'b00100,
    FCR_DATA = 5'b01000,
    FCR_IGNORE = 5'b10000
  } fcr_state_e;

endpackage

// File: design/fcr_cdc_if.sv
// signals crossing between the system clock side and the link side
interface fcr_cdc_if;
  logic cfg_ser;
  logic cfg_bin;
  logic lnk_active;
  logic lnk_cmd_tgl;

  modport sys (output cfg_ser, output cfg_bin,
               input lnk_active, input lnk_cmd_tgl);
  modport lnk (input cfg_ser, input cfg_bin,
               output lnk_active, output lnk_cmd_tgl);
endinterface

// File: design/fcr_sys_ctl.sv
// system clock side: configuration registers and link status
module fcr_sys_ctl
  import fcr_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic interface_select_i,
  input wire logic page_binary_i,
  fcr_cdc_if.sys cdc,
  output logic read_active_o,
  output logic cmd_start_o,
  output logic serial_mode_o
);

  logic sel_meta_q, sel_meta_d, sel_sync_q, sel_sync_d;
  logic ser_q, ser_d, bin_q, bin_d;
  logic act_meta_q, act_meta_d, act_sync_q, act_sync_d;
  logic tgl_meta_q, tgl_meta_d, tgl_sync_q, tgl_sync_d;
  logic tgl_seen_q, tgl_seen_d, pulse_q, pulse_d;

  // synchronisers, config registers and toggle edge detect
  always_comb begin
    sel_meta_d = interface_select_i;
    sel_sync_d = sel_meta_q;
    ser_d = sel_sync_q;
    bin_d = page_binary_i;
    act_meta_d = cdc.lnk_active;
    act_sync_d = act_meta_q;
    tgl_meta_d = cdc.lnk_cmd_tgl;
    tgl_sync_d = tgl_meta_q;
    tgl_seen_d = tgl_sync_q;
    pulse_d = tgl_sync_q ^ tgl_seen_q;
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sel_meta_q <= 1'b1;
      sel_sync_q <= 1'b1;
      ser_q <= 1'b1;
      bin_q <= 1'b0;
      act_meta_q <= 1'b0;
      act_sync_q <= 1'b0;
      tgl_meta_q <= 1'b0;
      tgl_sync_q <= 1'b0;
      tgl_seen_q <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      sel_meta_q <= sel_meta_d;
      sel_sync_q <= sel_sync_d;
      ser_q <= ser_d;
      bin_q <= bin_d;
      act_meta_q <= act_meta_d;
      act_sync_q <= act_sync_d;
      tgl_meta_q <= tgl_meta_d;
      tgl_sync_q <= tgl_sync_d;
      tgl_seen_q <= tgl_seen_d;
      pulse_q <= pulse_d;
    end
  end

  assign cdc.cfg_ser = ser_q;
  assign cdc.cfg_bin = bin_q;
  assign read_active_o = act_sync_q;
  assign cmd_start_o = pulse_q;
  assign serial_mode_o = ser_q;

endmodule

// File: dv/fcr_host.sv
// host model that frames read commands onto the link pins
module fcr_host (
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  output logic [7:0] pio_o,
  input wire logic so_i,
  input wire logic so_oe_i,
  input wire logic [7:0] pio_i,
  input wire logic [7:0] pio_oe_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rd [0:7];
  int oe_cnt;
  int xo_cnt;

  // idle pins at time zero; outside frames the clock rests at the mode level except for idle pulses
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    pio_o = 8'h00;
  end

  // one clock pulse; data was set up in the low phase
  task automatic pulse();
    #32 sck_o = 1'b1;
    #32 sck_o = 1'b0;
  endtask

  // two pulses with chip select high so config reaches the link side
  task automatic idle();
    sck_o = 1'b0;
    pulse();
    pulse();
  endtask

  // send one byte: eight bits on the serial pin or one parallel word
  task automatic put(input logic ser, input logic [7:0] b);
    if (!ser) begin
      pio_o = b;
      pulse();
    end else begin
      for (int i = 7; i >= 0; i--) begin
        si_o = b[i];
        pulse();
      end
    end
  endtask

  // take one byte on the rising edge, noting which ports were driven
  task automatic get(input logic ser, output logic [7:0] b);
    if (!ser) begin
      #32 sck_o = 1'b1;
      b = pio_i;
      if (pio_oe_i === 8'hff) oe_cnt++;
      if (so_oe_i !== 1'b0) xo_cnt++;
      #32 sck_o = 1'b0;
    end else begin
      for (int i = 7; i >= 0; i--) begin
        #32 sck_o = 1'b1;
        b[i] = so_i;
        if (so_oe_i === 1'b1) oe_cnt++;
        if (pio_oe_i !== 8'h00) xo_cnt++;
        #32 sck_o = 1'b0;
      end
    end
  endtask

  // a whole frame: opcode, address, dummies, then n bytes of data
  task automatic frame(input logic ser, input logic m3,
      input logic [7:0] opc, input logic [23:0] adr,
      input int nd, input int n);
    oe_cnt = 0;
    xo_cnt = 0;
    #12 sck_o = m3;
    #20 cs_n_o = 1'b0;
    if (m3) #32 sck_o = 1'b0;
    put(ser, opc);
    for (int k = 2; k >= 0; k--) put(ser, adr[k*8 +: 8]);
    for (int k = 0; k < nd; k++) put(ser, ~opc);
    for (int k = 0; k < n; k++) get(ser, rd[k]);
    #20 cs_n_o = 1'b1;
    #20 sck_o = m3;
    si_o = ~si_o;
    pio_o = ~pio_o;
  endtask
endmodule

// File: dv/test_fcr_flash_read.sv
// self-checking bench for the continuous array read front end
module test_fcr_flash_read
  import fcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_i, sys_rst_i, sel, pbin, sck, cs_n, si, so, so_oe;
  logic cs_p, ra, smode, so_pin;
  logic [7:0] pio_in, pio_out, pio_oe, arr_data, pio_pin;
  logic [PAGE_W-1:0] pg;
  logic [COL_W-1:0] col;
  int failures, cmp_count;
  int starts = 0;
  int ra_cnt = 0;
  logic [7:0] opcs [0:2] = '{OPC_LEGACY, OPC_HIGH, OPC_LOW};

  fcr_flash_read dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .interface_select_i(sel), .page_binary_i(pbin), .sck_i(sck),
    .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_o(so_oe),
    .pio_i(pio_in), .pio_o(pio_out), .pio_oe_o(pio_oe),
    .arr_page_o(pg), .arr_col_o(col), .arr_data_i(arr_data),
    .read_active_o(ra), .cmd_start_o(cs_p), .serial_mode_o(smode));

  fcr_host host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .pio_o(pio_in),
    .so_i(so_pin), .so_oe_i(so_oe), .pio_i(pio_pin), .pio_oe_i(pio_oe));

  // released pins show the inverse so a sample while floating is caught
  assign so_pin = so_oe ? so : ~so;
  assign pio_pin = (pio_oe == 8'hff) ? pio_out : ~pio_out;

  // array content as a fixed function of page and column
  function automatic logic [7:0] abyte(input logic [12:0] p,
      input logic [10:0] c);
    return c[7:0] ^ {c[10:8], p[4:0]} ^ p[12:5];
  endfunction
  assign arr_data = abyte(pg, col);

  // next page and column after one byte
  function automatic logic [23:0] step(input logic b, input logic [23:0] a);
    logic [12:0] p;
    logic [10:0] c;
    p = a[23:11];
    c = a[10:0];
    if (c >= (b ? 11'h3ff : 11'h41f)) begin
      c = 11'h000;
      p = p + 13'h0001;
    end else begin
      c = c + 11'h001;
    end
    return {p, c};
  endfunction

  // random address inside the page size in use
  function automatic logic [23:0] radr(input logic b);
    logic [12:0] p;
    p = 13'($urandom);
    if (b) return {1'($urandom), p, 10'($urandom)};
    return {p, 11'($urandom_range(0, 1055))};
  endfunction

  // system clock generation
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  // count opcode pulses and data phase cycles away from the launch edge
  always @(negedge sys_clk_i) begin
    if (cs_p === 1'b1) starts++;
    if (ra === 1'b1) ra_cnt++;
  end

  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // change port and page size between frames
  task automatic cfg(input logic s, input logic b);
    @(negedge sys_clk_i);
    sel = s;
    pbin = b;
    repeat (6) @(negedge sys_clk_i);
    host.idle();
    chk("smode", s, smode);
  endtask

  // one frame with expectations worked out from the address
  task automatic run(input logic ser, input logic m3,
      input logic [7:0] opc, input logic [23:0] adr, input int n);
    logic [23:0] a;
    logic ok;
    int nd, s0, r0;
    ok = opc == OPC_LEGACY || (ser && (opc == OPC_HIGH || opc == OPC_LOW));
    nd = opc == OPC_LEGACY ? (ser ? 4 : 19) : int'(opc == OPC_HIGH);
    a = pbin ? {adr[22:10], 1'b0, adr[9:0]} : adr;
    s0 = starts;
    r0 = ra_cnt;
    host.frame(ser, m3, opc, adr, nd, n);
    #1;
    chk("oe_off", 9'h000, {so_oe, pio_oe});
    chk("oe_cnt", ok ? n * (ser ? 8 : 1) : 0, host.oe_cnt);
    chk("xo_cnt", 0, host.xo_cnt);
    for (int k = 0; k < n && ok; k++) begin
      chk("data", abyte(a[23:11], a[10:0]), host.rd[k]);
      a = step(pbin, a);
    end
    repeat (6) @(negedge sys_clk_i);
    chk("starts", 32'(ok), starts - s0);
    chk("ra_seen", 32'(ok), 32'(ra_cnt > r0));
    chk("ra_idle", 0, ra);
  endtask

  task automatic test_done();
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    #1ms;
    failures++;
    $display("BAD watchdog expected end seen hang");
    test_done();
  end

  // main sequence: corners first, then random frames
  initial begin
    sys_rst_i = 1'b1;
    sel = 1'b1;
    pbin = 1'b0;
    failures = 0;
    cmp_count = 0;
    void'($urandom(77731));
    repeat (5) @(negedge sys_clk_i);
    chk("smode_rst", 1, smode);
    sys_rst_i = 1'b0;
    cfg(1, 0);
    run(1, 0, OPC_LOW, radr(0), 3);
    run(1, 1, OPC_HIGH, {13'h0005, 11'h41e}, 3);
    run(1, 0, 8'h5a, radr(0), 2);
    cfg(1, 1);
    run(1, 0, OPC_LEGACY, {1'b1, 13'h1fff, 10'h3ff}, 2);
    cfg(0, 0);
    run(0, 1, OPC_LEGACY, {13'h1fff, 11'h41f}, 4);
    run(0, 0, OPC_HIGH, radr(0), 2);
    run(0, 0, OPC_LOW, radr(0), 2);
    for (int i = 0; i < 14; i++) begin
      cfg(1'($urandom), 1'($urandom));
      run(sel, 1'($urandom), opcs[$urandom_range(0, 2)], radr(pbin),
        $urandom_range(1, 8));
    end
    test_done();
  end
endmodule
